/* File: hw/scpr_pkg.sv */
// Constants and carrier types for the synthesizer control block.
// Assumes 18-bit control words written only over the three-wire serial port.
package scpr_pkg;
    // Frame geometry
    localparam int FRAME_BITS = 22;
    localparam int DATA_BITS  = 18;
    localparam int ADDR_BITS  = 4;
    localparam int RDIV_BITS  = 13;
    localparam int NUM_REGS   = 9;
    // Register addresses
    localparam logic [3:0] ADDR_MAIN     = 4'h0;
    localparam logic [3:0] ADDR_GAIN     = 4'h1;
    localparam logic [3:0] ADDR_POWER    = 4'h2;
    localparam logic [3:0] ADDR_RF_HI_N  = 4'h3;
    localparam logic [3:0] ADDR_RF_LO_N  = 4'h4;
    localparam logic [3:0] ADDR_IF_N     = 4'h5;
    localparam logic [3:0] ADDR_RF_HI_R  = 4'h6;
    localparam logic [3:0] ADDR_RF_LO_R  = 4'h7;
    localparam logic [3:0] ADDR_IF_R     = 4'h8;
    // Main configuration fields
    localparam int AUX_SEL_LSB  = 12;
    localparam int IF_DIV_LSB   = 10;
    localparam int LOW_BIAS_BIT = 5;
    localparam int FORCE_ON_BIT = 3;
    // Section power enable fields
    localparam int IF_ON_BIT = 1;
    localparam int RF_ON_BIT = 0;
    // Aux select codes
    localparam logic [1:0] AUX_FORCE_LOW = 2'h1;
    localparam logic [1:0] AUX_LOCK_WARN = 2'h3;
    // Reset values
    localparam logic [17:0] REG_RESET = 18'h0_0000;
    localparam logic [3:0]  PIN_RESET = 4'h1;
    // Update-period counts
    localparam logic [5:0] TUNE_PERIODS   = 6'h0d;
    localparam logic [5:0] TOTAL_PERIODS  = 6'h28;
    localparam logic [5:0] SETTLE_PERIODS = TOTAL_PERIODS - TUNE_PERIODS;
    localparam logic [5:0] TUNE_LAST      = TUNE_PERIODS - 6'h1;
    localparam logic [5:0] SETTLE_LAST    = SETTLE_PERIODS - 6'h1;
    // One serial frame: data first, address last
    typedef struct packed {
        logic [17:0] data;
        logic [3:0]  addr;
    } scpr_frame_t;
    // Divider and gain settings handed to the analog loops
    typedef struct packed {
        logic [17:0] rf_hi_n;
        logic [16:0] rf_lo_n;
        logic [15:0] if_n;
        logic [12:0] rf_hi_r;
        logic [12:0] rf_lo_r;
        logic [12:0] if_r;
        logic [5:0]  gains;
    } scpr_div_t;
endpackage

/* File: hw/scpr_pll_seq.sv */
// Self-tune and settle sequencer for one PLL, counted in update periods.
// Assumes i_ref_rise is a one-cycle pulse per reference edge.
module scpr_pll_seq (
    // Clock and reset
    input  wire logic                             i_core_clk,
    input  wire logic                             i_rst,
    // Control
    input  wire logic                             i_on,
    input  wire logic                             i_restart,
    input  wire logic [scpr_pkg::RDIV_BITS-1:0]   i_r_div,
    input  wire logic                             i_ref_rise,
    // Status
    output logic                                  o_tuning,
    output logic                                  o_settled
);
    import scpr_pkg::*;

    typedef enum logic [1:0] {SEQ_OFF, SEQ_TUNE, SEQ_SETTLE, SEQ_DONE} scpr_seq_t;
    scpr_seq_t                state_reg;
    logic [RDIV_BITS-1:0]     ref_cnt_reg;
    logic [5:0]               per_cnt_reg;
    logic                     on_prev_reg;
    logic                     start;
    logic                     tick;

    // Power-up or new frequency starts a fresh tune
    assign start = i_on && (!on_prev_reg || i_restart);
    // Reference divided by R marks one update period
    assign tick  = i_ref_rise && (ref_cnt_reg + 13'h1 >= i_r_div);
    assign o_tuning  = (state_reg == SEQ_TUNE);
    assign o_settled = (state_reg == SEQ_DONE);

    // Reference divider
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ref_cnt_reg <= '0;
        end else if (!i_on || start || tick) begin
            ref_cnt_reg <= '0;
        end else if (i_ref_rise) begin
            ref_cnt_reg <= ref_cnt_reg + 13'h1;
        end
    end

    // Phase sequencer
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg   <= SEQ_OFF;
            per_cnt_reg <= '0;
            on_prev_reg <= 1'b0;
        end else begin
            on_prev_reg <= i_on;
            if (!i_on) begin
                state_reg   <= SEQ_OFF;
                per_cnt_reg <= '0;
            end else if (start) begin
                state_reg   <= SEQ_TUNE;
                per_cnt_reg <= '0;
            end else if (tick) begin
                unique case (state_reg)
                    SEQ_OFF: begin
                        state_reg <= SEQ_TUNE;
                    end
                    SEQ_TUNE: begin
                        per_cnt_reg <= (per_cnt_reg == TUNE_LAST) ? '0 : per_cnt_reg + 6'h1;
                        if (per_cnt_reg == TUNE_LAST) state_reg <= SEQ_SETTLE;
                    end
                    SEQ_SETTLE: begin
                        per_cnt_reg <= per_cnt_reg + 6'h1;
                        if (per_cnt_reg == SETTLE_LAST) state_reg <= SEQ_DONE;
                    end
                    SEQ_DONE: begin
                        per_cnt_reg <= '0;
                    end
                endcase
            end
        end
    end

    sequence s_tune_end;
        state_reg == SEQ_TUNE && tick && per_cnt_reg == TUNE_LAST && i_on && !start;
    endsequence
    sequence s_settle_end;
        state_reg == SEQ_SETTLE && tick && per_cnt_reg == SETTLE_LAST && i_on && !start;
    endsequence

    chk_start_tunes: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        start |=> o_tuning && per_cnt_reg == 6'h0)
        else $error("tune did not start");
    chk_tune_length: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        s_tune_end |=> state_reg == SEQ_SETTLE && !o_tuning)
        else $error("tune phase length wrong");
    chk_settle_done: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        s_settle_end |=> o_settled)
        else $error("settle phase length wrong");
    chk_tune_hold: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        o_tuning && !tick && i_on && !start |=> o_tuning && $stable(per_cnt_reg))
        else $error("tune count moved without a period");
endmodule

/* File: hw/scpr_serial_link.sv */
// Serial shift register running on the link clock.
// Assumes the link clock toggles only while the enable is low.
module scpr_serial_link (
    // Link clock and reset
    input  wire logic          i_sclk,
    input  wire logic          i_rst,
    // Serial pins
    input  wire logic          i_serial_enable_n,
    input  wire logic          i_serial_data_in,
    // Captured frame, stable while the enable is high
    output scpr_pkg::scpr_frame_t o_frame
);
    import scpr_pkg::*;

    // Shift in while enabled, oldest bits fall off the top
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            o_frame <= '0;
        end else if (!i_serial_enable_n) begin
            o_frame <= {o_frame[FRAME_BITS-2:0], i_serial_data_in};
        end
    end

    chk_shift_keep: assert property (
        @(posedge i_sclk) disable iff (i_rst)
        !i_serial_enable_n |=> o_frame[0] == $past(i_serial_data_in)
            && o_frame[FRAME_BITS-1:1] == $past(o_frame[FRAME_BITS-2:0]))
        else $error("serial shift lost a bit");
endmodule

/* File: hw/scpr_top.sv */
// Control logic of the triple-PLL synthesizer: serial registers,
// power decode, RF source pick, aux pin and tune sequencing.
// Assumes the link clock belongs to the host and stops between frames;
// all pins other than the link clock are asynchronous to the core clock.
module scpr_top (
    // Core clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_rst,
    // Serial port
    input  wire logic                 i_sclk,
    input  wire logic                 i_serial_enable_n,
    input  wire logic                 i_serial_data_in,
    // Pins and analog monitors
    input  wire logic                 i_chip_sleep_pin_n,
    input  wire logic                 i_reference_input_pin,
    input  wire logic                 i_drift_limit_near,
    // Section enables
    output logic                      o_if_power_on,
    output logic                      o_rf_power_on,
    output logic                      o_ref_amp_on,
    // Output path controls
    output logic                      o_rf_src_low_band,
    output logic                      o_if_out_low_bias,
    output logic [1:0]                o_if_post_divide,
    output logic                      o_aux_pin,
    // Loop settings and status
    output scpr_pkg::scpr_div_t       o_div,
    output logic                      o_if_settled,
    output logic                      o_rf_settled
);
    import scpr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    ////////////////////////////////////////////////////////////////////

    localparam int PIN_ENABLE = 0;
    localparam int PIN_SLEEP  = 1;
    localparam int PIN_REF    = 2;
    localparam int PIN_DRIFT  = 3;

    logic [3:0]          pin_raw;
    logic [3:0]          pin_reg;
    logic                en_prev_reg;
    logic                ref_prev_reg;
    logic                commit;
    logic                ref_rise;
    logic                sleep_n;

    assign pin_raw = {i_drift_limit_near, i_reference_input_pin,
                      i_chip_sleep_pin_n, i_serial_enable_n};

    // Three stages; a change counts once stages two and three agree
    generate
        for (genvar g = 0; g < 4; g++) begin : g_sync
            logic [2:0] stage_reg;
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    stage_reg  <= {3{PIN_RESET[g]}};
                    pin_reg[g] <= PIN_RESET[g];
                end else begin
                    stage_reg <= {stage_reg[1:0], pin_raw[g]};
                    if (stage_reg[1] == stage_reg[2]) begin
                        pin_reg[g] <= stage_reg[2];
                    end
                end
            end
        end
    endgenerate

    // Edge history of the filtered pins
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            en_prev_reg  <= 1'b1;
            ref_prev_reg <= 1'b0;
        end else begin
            en_prev_reg  <= pin_reg[PIN_ENABLE];
            ref_prev_reg <= pin_reg[PIN_REF];
        end
    end

    // Enable release closes a frame; the link word is then quiet
    assign commit   = pin_reg[PIN_ENABLE] && !en_prev_reg;
    assign ref_rise = pin_reg[PIN_REF] && !ref_prev_reg;
    assign sleep_n  = pin_reg[PIN_SLEEP];

    ////////////////////////////////////////////////////////////////////
    // Serial link
    ////////////////////////////////////////////////////////////////////

    scpr_frame_t         link_frame;

    scpr_serial_link u_link (
        .i_sclk            (i_sclk),
        .i_rst             (i_rst),
        .i_serial_enable_n (i_serial_enable_n),
        .i_serial_data_in  (i_serial_data_in),
        .o_frame           (link_frame)
    );

    ////////////////////////////////////////////////////////////////////
    // Control registers
    ////////////////////////////////////////////////////////////////////

    logic [DATA_BITS-1:0] ctrl_reg [NUM_REGS];
    logic                 addr_ok;
    logic                 if_restart_reg;
    logic                 rf_restart_reg;

    // Reserved addresses 9 to 15 are dropped
    assign addr_ok = (link_frame.addr <= ADDR_IF_R);

    // Write-only store, open in every power state
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                ctrl_reg[i] <= REG_RESET;
            end
        end else if (commit && addr_ok) begin
            ctrl_reg[link_frame.addr] <= link_frame.data;
        end
    end

    // Divider writes restart the matching loop
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            if_restart_reg <= 1'b0;
            rf_restart_reg <= 1'b0;
        end else begin
            if_restart_reg <= commit && (link_frame.addr == ADDR_IF_N
                                      || link_frame.addr == ADDR_IF_R);
            rf_restart_reg <= commit && (link_frame.addr == ADDR_RF_HI_N
                                      || link_frame.addr == ADDR_RF_LO_N
                                      || link_frame.addr == ADDR_RF_HI_R
                                      || link_frame.addr == ADDR_RF_LO_R);
        end
    end

    // RF source follows the last RF divider written
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rf_src_low_band <= 1'b0;
        end else if (commit) begin
            if (link_frame.addr == ADDR_RF_HI_N || link_frame.addr == ADDR_RF_HI_R) begin
                o_rf_src_low_band <= 1'b0;
            end else if (link_frame.addr == ADDR_RF_LO_N
                         || link_frame.addr == ADDR_RF_LO_R) begin
                o_rf_src_low_band <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power decode
    ////////////////////////////////////////////////////////////////////

    logic [DATA_BITS-1:0] main_cfg;
    logic [DATA_BITS-1:0] power_cfg;
    logic                 force_on;
    logic                 if_on_next;
    logic                 rf_on_next;

    assign main_cfg   = ctrl_reg[ADDR_MAIN];
    assign power_cfg  = ctrl_reg[ADDR_POWER];
    assign force_on   = main_cfg[FORCE_ON_BIT];
    // Pin low wins, then force-all-on, then the enable bits
    assign if_on_next = sleep_n && (force_on || power_cfg[IF_ON_BIT]);
    assign rf_on_next = sleep_n && (force_on || power_cfg[RF_ON_BIT]);

    // Registered section enables
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_if_power_on <= 1'b0;
            o_rf_power_on <= 1'b0;
            o_ref_amp_on  <= 1'b0;
        end else begin
            o_if_power_on <= if_on_next;
            o_rf_power_on <= rf_on_next;
            o_ref_amp_on  <= if_on_next || rf_on_next;
        end
    end

    // IF output stage controls
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_if_out_low_bias <= 1'b0;
            o_if_post_divide  <= 2'h0;
        end else begin
            o_if_out_low_bias <= main_cfg[LOW_BIAS_BIT];
            o_if_post_divide  <= main_cfg[IF_DIV_LSB+1:IF_DIV_LSB];
        end
    end

    // Divider and gain settings to the loops
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_div <= '0;
        end else begin
            o_div.rf_hi_n <= ctrl_reg[ADDR_RF_HI_N];
            o_div.rf_lo_n <= ctrl_reg[ADDR_RF_LO_N][16:0];
            o_div.if_n    <= ctrl_reg[ADDR_IF_N][15:0];
            o_div.rf_hi_r <= ctrl_reg[ADDR_RF_HI_R][RDIV_BITS-1:0];
            o_div.rf_lo_r <= ctrl_reg[ADDR_RF_LO_R][RDIV_BITS-1:0];
            o_div.if_r    <= ctrl_reg[ADDR_IF_R][RDIV_BITS-1:0];
            o_div.gains   <= ctrl_reg[ADDR_GAIN][5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Tune sequencing
    ////////////////////////////////////////////////////////////////////

    logic                 if_tuning;
    logic                 rf_tuning;
    logic                 if_settled;
    logic                 rf_settled;
    logic [RDIV_BITS-1:0] rf_r_sel;
    logic                 warning;

    assign rf_r_sel = o_rf_src_low_band ? ctrl_reg[ADDR_RF_LO_R][RDIV_BITS-1:0]
                                        : ctrl_reg[ADDR_RF_HI_R][RDIV_BITS-1:0];

    scpr_pll_seq u_if_seq (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_on       (o_if_power_on),
        .i_restart  (if_restart_reg),
        .i_r_div    (ctrl_reg[ADDR_IF_R][RDIV_BITS-1:0]),
        .i_ref_rise (ref_rise),
        .o_tuning   (if_tuning),
        .o_settled  (if_settled)
    );

    scpr_pll_seq u_rf_seq (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_on       (o_rf_power_on),
        .i_restart  (rf_restart_reg),
        .i_r_div    (rf_r_sel),
        .i_ref_rise (ref_rise),
        .o_tuning   (rf_tuning),
        .o_settled  (rf_settled)
    );

    // Warning is high while tuning or near the drift limit
    assign warning = if_tuning || rf_tuning || pin_reg[PIN_DRIFT];

    // Aux pin and settle flags
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_aux_pin    <= 1'b0;
            o_if_settled <= 1'b0;
            o_rf_settled <= 1'b0;
        end else begin
            o_if_settled <= if_settled;
            o_rf_settled <= rf_settled;
            unique case (main_cfg[AUX_SEL_LSB+1:AUX_SEL_LSB])
                AUX_LOCK_WARN: o_aux_pin <= warning;
                AUX_FORCE_LOW: o_aux_pin <= 1'b0;
                default:       o_aux_pin <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////

    chk_sleep_all_off: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !sleep_n |=> !o_if_power_on && !o_rf_power_on && !o_ref_amp_on)
        else $error("section on while sleep pin low");

    chk_bits_switch: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        sleep_n && !force_on |=> o_if_power_on == $past(power_cfg[IF_ON_BIT])
            && o_rf_power_on == $past(power_cfg[RF_ON_BIT]))
        else $error("enable bits not followed");

    chk_force_on: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        sleep_n && force_on |=> o_if_power_on && o_rf_power_on)
        else $error("force-all-on not honoured");

    chk_ref_amp: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        o_ref_amp_on == (o_if_power_on || o_rf_power_on))
        else $error("reference amplifier state wrong");

    chk_write_sleep: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        commit && !sleep_n && link_frame.addr == ADDR_POWER
            |=> power_cfg == $past(link_frame.data))
        else $error("write lost while asleep");

    chk_rf_source: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        commit && (link_frame.addr == ADDR_RF_LO_N || link_frame.addr == ADDR_RF_LO_R)
            |=> o_rf_src_low_band ##1 o_rf_src_low_band)
        else $error("RF source not switched to low band");

    chk_low_bias: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        commit && link_frame.addr == ADDR_MAIN
            |=> ##1 o_if_out_low_bias == $past(link_frame.data[LOW_BIAS_BIT], 2))
        else $error("low-bias bit not applied");

    chk_aux_warn: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        main_cfg[AUX_SEL_LSB+1:AUX_SEL_LSB] == AUX_LOCK_WARN |=> o_aux_pin == $past(warning))
        else $error("aux pin not showing warning");

    chk_aux_low: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        main_cfg[AUX_SEL_LSB+1:AUX_SEL_LSB] == AUX_FORCE_LOW |=> !o_aux_pin)
        else $error("aux pin not forced low");

    chk_no_stray_write: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !commit |=> $stable(power_cfg) && $stable(main_cfg))
        else $error("register changed without frame end");

    chk_rf_source_high: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        commit && (link_frame.addr == ADDR_RF_HI_N || link_frame.addr == ADDR_RF_HI_R)
            |=> !o_rf_src_low_band)
        else $error("RF source not switched to high band");

    chk_aux_reserved: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !main_cfg[AUX_SEL_LSB] |=> !o_aux_pin)
        else $error("aux pin not low for reserved code");

    chk_if_retune: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        commit && (link_frame.addr == ADDR_IF_N || link_frame.addr == ADDR_IF_R)
            && o_if_power_on && if_on_next |=> ##1 if_tuning)
        else $error("IF divider write did not restart tuning");

    chk_rf_retune: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        commit && (link_frame.addr == ADDR_RF_HI_N || link_frame.addr == ADDR_RF_LO_N)
            && o_rf_power_on && rf_on_next |=> ##1 rf_tuning)
        else $error("RF divider write did not restart tuning");
endmodule

/* File: test/scpr_host_model.sv */
// Host controller model driving the three-wire serial port.
// Spaces frames itself with an idle gap after each release; the link clock runs only inside a frame.
module scpr_host_model (
    // Serial pins
    output logic o_sclk,
    output logic o_serial_enable_n,
    output logic o_serial_data_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle port: enable high, clock parked low
    initial begin
        o_sclk = 1'b0;
        o_serial_enable_n = 1'b1;
        o_serial_data_in = 1'b0;
    end

    // Shifts n bits MSB first at a 30 ns link period, then releases the port
    task automatic send(input logic [25:0] bits, input int n);
        o_serial_enable_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_serial_data_in = bits[i];
            #15 o_sclk = 1'b1;
            #15 o_sclk = 1'b0;
        end
        #15 o_serial_enable_n = 1'b1;
        // Released line shows no stale bit
        o_serial_data_in = ~o_serial_data_in;
        // Long idle gap lets the word land before the next frame
        #120;
    endtask
endmodule

/* File: test/scpr_top_bench.sv */
// Self-checking bench for the synthesizer control block.
// Assumes the host model for the serial pins; all other pins driven here.
module scpr_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import scpr_pkg::*;
    logic       clk, rst, sleep_n, ref_pin, drift, sclk, en_n, sdi;
    logic       if_on, rf_on, ref_on, src_lo, low_bias, aux, if_set, rf_set;
    logic [1:0] post_div;
    scpr_div_t  div;
    int         err_count = 0;
    int         comparisons = 0;
    logic [3:0] rf_a [4] = '{ADDR_RF_LO_N, ADDR_RF_HI_R, ADDR_RF_LO_R, ADDR_RF_HI_N};

    ////////////////////////////////////////////////////////////////////////////////
    scpr_host_model i_scpr_host_model (.o_sclk(sclk), .o_serial_enable_n(en_n),
        .o_serial_data_in(sdi));
    scpr_top i_scpr_top (.i_core_clk(clk), .i_rst(rst), .i_sclk(sclk),
        .i_serial_enable_n(en_n), .i_serial_data_in(sdi), .i_chip_sleep_pin_n(sleep_n),
        .i_reference_input_pin(ref_pin), .i_drift_limit_near(drift), .o_if_power_on(if_on),
        .o_rf_power_on(rf_on), .o_ref_amp_on(ref_on), .o_rf_src_low_band(src_lo),
        .o_if_out_low_bias(low_bias), .o_if_post_divide(post_div), .o_aux_pin(aux),
        .o_div(div), .o_if_settled(if_set), .o_rf_settled(rf_set));

    // Core clock and a 64 ns reference
    always #2 clk = ~clk;
    always #32 ref_pin = ~ref_pin;

    ////////////////////////////////////////////////////////////////////////////////
    // Register write; only addresses 0 to 8 are ever used
    task automatic wr(input logic [3:0] a, input logic [17:0] d);
        i_scpr_host_model.send({4'h0, d, a}, 22);
    endtask

    // Pin change just after an edge, then time to pass the synchronisers
    task automatic drive(input logic s, input logic d);
        @(posedge clk);
        #1;
        sleep_n = s;
        drift = d;
        repeat (10) @(posedge clk);
    endtask

    // Packed view of the output controls
    function automatic logic [17:0] st();
        return {11'h000, post_div, low_bias, aux, ref_on, if_on, rf_on};
    endfunction

    task automatic chk(input logic [17:0] act, input logic [17:0] exp);
        comparisons++;
        if (act !== exp) begin
            err_count++;
            $display("[ERR] t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic end_sim();
        $display("err_count=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the expected 14 us run
    initial begin
        #100000;
        err_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sleep_n = 1'b1;
        ref_pin = 1'b0;
        drift = 1'b0;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk);
        // Every enable pair, pin high, force bit clear
        for (int k = 3; k >= 0; k--) begin
            wr(ADDR_POWER, 18'(k));
            chk(st(), {15'h0000, k != 0, k[1:0]});
        end
        drive(1'b1, 1'b1);
        wr(ADDR_MAIN, 18'h0_3428);
        chk(st(), {11'h000, 2'h1, 1'b1, 1'b1, 3'h7});
        drive(1'b0, 1'b1);
        wr(ADDR_MAIN, 18'h0_1008);
        wr(ADDR_POWER, 18'h0_0002);
        chk(st(), 18'h0_0000);
        drive(1'b1, 1'b0);
        chk(st(), 18'h0_0007);
        // Source follows the last RF divider written; R of 1 keeps the RF loop quick
        for (int k = 0; k < 4; k++) begin
            wr(rf_a[k], 18'h0_2001);
            chk({17'h0_0000, src_lo}, 18'(k % 2 == 0));
        end
        chk({1'b0, div.rf_lo_n}, 18'h0_2001);
        // Leading junk bits ahead of gain codes picked for N of 8193
        i_scpr_host_model.send({4'hf, 18'h0_000e, ADDR_GAIN}, 26);
        chk({12'h000, div.gains}, 18'h0_000e);
        // Restart the IF loop with R of 1 and time its phases
        wr(ADDR_MAIN, 18'h0_3008);
        wr(ADDR_IF_R, 18'h0_0001);
        chk({5'h00, div.if_r}, 18'h0_0001);
        #(6 * 64) chk({17'h0_0000, aux}, 18'h0_0001);
        #(14 * 64) chk({17'h0_0000, aux}, 18'h0_0000);
        #(16 * 64) chk({17'h0_0000, if_set}, 18'h0_0000);
        #(8 * 64) chk({16'h0000, if_set, rf_set}, 18'h0_0003);
        end_sim();
    end
endmodule
